/* ead_pkg.sv */
// Constants, types and tables shared by the external area decoder
package ead_pkg;

  localparam int ADDR_W = 32;
  localparam int AREA_LSB = 26;
  localparam int AREA_MSB = 28;
  localparam int CARD_IO_BIT = 25;
  localparam int MUX_ADDR_W = 26;
  localparam int ROW_SHIFT_BASE = 8;

  localparam logic [2:0] AREA0 = 3'h0;
  localparam logic [2:0] AREA1 = 3'h1;
  localparam logic [2:0] AREA2 = 3'h2;
  localparam logic [2:0] AREA3 = 3'h3;
  localparam logic [2:0] AREA4 = 3'h4;
  localparam logic [2:0] AREA5 = 3'h5;
  localparam logic [2:0] AREA6 = 3'h6;
  localparam logic [2:0] AREA_NONE = 3'h7;
  localparam int NUM_AREAS = 7;

  localparam logic [1:0] W_BYTE = 2'h1;
  localparam logic [1:0] W_WORD = 2'h2;
  localparam logic [1:0] W_LONG = 2'h3;

  // Index bit 3 is the card-mode extra wait bit
  localparam logic [5:0] WAIT_TABLE [16] = '{
    6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h08, 6'h0A,
    6'h0C, 6'h0E, 6'h12, 6'h16, 6'h1A, 6'h1E, 6'h22, 6'h26
  };

  // Burst pitch is two clocks plus these waits at most
  localparam logic [5:0] BURST_MAX_A0 = 6'h08;
  localparam logic [5:0] BURST_MAX_ORD = 6'h09;
  localparam logic [5:0] BURST_MAX_CARD = 6'h25;
  localparam logic [1:0] BEAT_LAST = 2'h3;

  localparam logic [5:0] CNT_RST = 6'h00;
  localparam logic [2:0] AREA_RST = 3'h0;
  localparam logic [1:0] BEAT_RST = 2'h0;

  typedef enum logic [2:0] {
    S_IDLE, S_SETUP, S_T1, S_TW, S_T2, S_HOLD, S_ACT, S_CMD
  } ead_state_t;

  typedef struct packed {
    logic [2:0] area0_wait_field;
    logic [1:0] area2_wait_field;
    logic [1:0] area3_wait_field;
    logic [2:0] area4_wait_field;
    logic [2:0] area5_wait_field;
    logic [2:0] area6_wait_field;
    logic area5_wait_extra_bit;
    logic area6_wait_extra_bit;
    logic [1:0] area2_size_field;
    logic [1:0] area3_size_field;
    logic [1:0] area4_size_field;
    logic [1:0] area5_size_field;
    logic [1:0] area6_size_field;
    logic area2_sdram;
    logic area3_sdram;
    logic area5_card;
    logic area6_card;
    logic [2:0] area5_strobe_setup_field;
    logic [2:0] area5_strobe_hold_field;
    logic [2:0] area6_strobe_setup_field;
    logic [2:0] area6_strobe_hold_field;
    logic [1:0] mux_shift;
  } ead_cfg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic [3:0] byte_en;
    logic burst;
  } ead_req_t;

endpackage

/* ead_wait_select.sv */
// Programmed wait count and external wait permission per area
`timescale 1ns/1ps
`default_nettype none
module ead_wait_select (
  input wire logic [2:0] area,
  input wire ead_pkg::ead_cfg_t cfg,
  input wire logic card,
  input wire logic sdram,
  input wire logic burst,
  output logic [5:0] waits,
  output logic ext_ok
);
  import ead_pkg::*;

  logic [3:0] code;
  logic [5:0] table_w;
  logic [5:0] short_w;
  logic [5:0] raw_w;
  logic [5:0] cap_w;

  // Extra bit only counts in card mode
  assign code = (area == AREA0) ? {1'b0, cfg.area0_wait_field} :
                (area == AREA4) ? {1'b0, cfg.area4_wait_field} :
                (area == AREA5) ? {card & cfg.area5_wait_extra_bit, cfg.area5_wait_field} :
                {card & cfg.area6_wait_extra_bit, cfg.area6_wait_field};
  assign table_w = WAIT_TABLE[code];
  assign short_w = (area == AREA2) ? {4'h0, cfg.area2_wait_field} : {4'h0, cfg.area3_wait_field};
  assign raw_w = (area == AREA2 || area == AREA3) ? short_w : table_w;
  assign cap_w = (area == AREA0) ? BURST_MAX_A0 : card ? BURST_MAX_CARD : BURST_MAX_ORD;
  assign waits = (burst && raw_w > cap_w) ? cap_w : raw_w;
  assign ext_ok = !sdram && area != AREA1 && area != AREA_NONE;
endmodule
`default_nettype wire

/* ead_area_decoder.sv */
// External area decoder: area select, strobes, waits and SDRAM/card steering
`timescale 1ns/1ps
`default_nettype none
module ead_area_decoder (
  input wire logic clk,
  input wire logic sys_rst,
  input wire ead_pkg::ead_cfg_t cfg,
  input wire logic area0_width_pin_a,
  input wire logic area0_width_pin_b,
  input wire logic req_valid,
  input wire ead_pkg::ead_req_t req,
  output logic req_ready,
  output logic req_done,
  output logic req_internal,
  input wire logic wait_n,
  output logic [1:0] bus_width,
  output logic [ead_pkg::MUX_ADDR_W-1:0] mem_addr,
  output logic area0_select_n,
  output logic area2_select_n,
  output logic area3_select_n,
  output logic area4_select_n,
  output logic area5_select_n,
  output logic area6_select_n,
  output logic read_strobe_n,
  output logic byte_write_strobe0_n,
  output logic byte_write_strobe1_n,
  output logic byte_write_strobe2_n,
  output logic byte_write_strobe3_n,
  output logic row_strobe_upper_n,
  output logic row_strobe_lower_n,
  output logic column_strobe_upper_n,
  output logic column_strobe_lower_n,
  output logic sdram_write_n,
  output logic byte_mask_0,
  output logic byte_mask_1,
  output logic byte_mask_2,
  output logic byte_mask_3,
  output logic card_a_enable1_n,
  output logic card_a_enable2_n,
  output logic card_b_enable1_n,
  output logic card_b_enable2_n,
  output logic card_io_read_n,
  output logic card_io_write_n
);
  import ead_pkg::*;

  ead_state_t state_r, state_nxt;
  ead_req_t req_r;
  logic [2:0] area_r;
  logic [5:0] cnt_r, cnt_nxt;
  logic [5:0] waits_r;
  logic [5:0] tw_len_r;
  logic [2:0] hold_r;
  logic [1:0] beat_r;
  logic [1:0] bus_width_r;
  logic wait_en_r, sdram_r, card_r, done_r, internal_r;

  logic accept;
  logic [2:0] req_area;
  logic ext_area, req_sdram, req_card;
  logic [2:0] req_setup, req_hold;
  logic [1:0] raw_width, req_width;
  logic [5:0] sel_waits;
  logic sel_ext_ok, sel_wait_en, ext_stall;
  logic in_cycle, strobe_ph, ord_sel, sd_ph, io_range;
  logic [NUM_AREAS-1:0] sel_hit;
  logic [3:0] we_hit;
  logic [ADDR_W-1:0] row_addr;

  // Upper address bits never reach the decode, which makes the shadows
  assign req_area = req.addr[AREA_MSB:AREA_LSB];
  assign accept = req_valid && state_r == S_IDLE;
  assign ext_area = req_area != AREA1 && req_area != AREA_NONE;
  assign req_sdram = (req_area == AREA2 && cfg.area2_sdram) ||
                     (req_area == AREA3 && cfg.area3_sdram);
  assign req_card = (req_area == AREA5 && cfg.area5_card) ||
                    (req_area == AREA6 && cfg.area6_card);
  assign req_setup = (req_area == AREA5) ? cfg.area5_strobe_setup_field :
                     (req_area == AREA6) ? cfg.area6_strobe_setup_field : 3'h0;
  assign req_hold = (req_area == AREA5) ? cfg.area5_strobe_hold_field :
                    (req_area == AREA6) ? cfg.area6_strobe_hold_field : 3'h0;

  assign raw_width = (req_area == AREA0) ? {area0_width_pin_b, area0_width_pin_a} :
                     (req_area == AREA2) ? cfg.area2_size_field :
                     (req_area == AREA3) ? cfg.area3_size_field :
                     (req_area == AREA4) ? cfg.area4_size_field :
                     (req_area == AREA5) ? cfg.area5_size_field : cfg.area6_size_field;
  // Cards are at most 16 bits wide, so a long setting falls back to word
  assign req_width = (req_card && raw_width == W_LONG) ? W_WORD : raw_width;

  ead_wait_select u_wait (
    .area(req_area),
    .cfg(cfg),
    .card(req_card),
    .sdram(req_sdram),
    .burst(req.burst),
    .waits(sel_waits),
    .ext_ok(sel_ext_ok)
  );

  assign sel_wait_en = sel_ext_ok && sel_waits != 6'h00;
  // Sampled only on the last programmed wait, then repeated while held low
  assign ext_stall = wait_en_r && !wait_n && cnt_r == 6'h01;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      S_IDLE: begin
        if (accept && ext_area) begin
          if (req_sdram) begin
            state_nxt = S_ACT;
          end else if (req_setup != 3'h0) begin
            state_nxt = S_SETUP;
            cnt_nxt = {3'h0, req_setup};
          end else begin
            state_nxt = S_T1;
          end
        end
      end
      S_SETUP: begin
        if (cnt_r == 6'h01) begin
          state_nxt = S_T1;
        end else begin
          cnt_nxt = cnt_r - 6'h01;
        end
      end
      S_T1: begin
        if (waits_r != 6'h00) begin
          state_nxt = S_TW;
          cnt_nxt = waits_r;
        end else begin
          state_nxt = S_T2;
        end
      end
      S_TW: begin
        if (cnt_r > 6'h01) begin
          cnt_nxt = cnt_r - 6'h01;
        end else if (!ext_stall) begin
          state_nxt = S_T2;
        end
      end
      S_T2: begin
        if (req_r.burst && beat_r != BEAT_LAST) begin
          state_nxt = S_T1;
        end else if (hold_r != 3'h0) begin
          state_nxt = S_HOLD;
          cnt_nxt = {3'h0, hold_r};
        end else begin
          state_nxt = S_IDLE;
        end
      end
      S_HOLD: begin
        if (cnt_r == 6'h01) begin
          state_nxt = S_IDLE;
        end else begin
          cnt_nxt = cnt_r - 6'h01;
        end
      end
      S_ACT: state_nxt = S_CMD;
      S_CMD: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= S_IDLE;
      cnt_r <= CNT_RST;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Request fields are captured once; the cycle runs from the copy
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_r <= '0;
      area_r <= AREA_RST;
      waits_r <= CNT_RST;
      hold_r <= 3'h0;
      bus_width_r <= W_BYTE;
      wait_en_r <= 1'b0;
      sdram_r <= 1'b0;
      card_r <= 1'b0;
    end else if (accept) begin
      req_r <= req;
      area_r <= req_area;
      waits_r <= sel_waits;
      hold_r <= req_hold;
      bus_width_r <= req_width;
      wait_en_r <= sel_wait_en;
      sdram_r <= req_sdram;
      card_r <= req_card;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      beat_r <= BEAT_RST;
    end else if (accept) begin
      beat_r <= BEAT_RST;
    end else if (state_r == S_T2 && state_nxt == S_T1) begin
      beat_r <= beat_r + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done_r <= 1'b0;
      internal_r <= 1'b0;
    end else begin
      done_r <= (accept && !ext_area) || (state_r != S_IDLE && state_nxt == S_IDLE);
      internal_r <= accept && !ext_area;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || state_r != S_TW) begin
      tw_len_r <= CNT_RST;
    end else begin
      tw_len_r <= tw_len_r + 6'h01;
    end
  end

  assign req_ready = state_r == S_IDLE;
  assign req_done = done_r;
  assign req_internal = internal_r;
  assign bus_width = bus_width_r;

  assign in_cycle = state_r inside {S_SETUP, S_T1, S_TW, S_T2, S_HOLD};
  assign strobe_ph = state_r inside {S_T1, S_TW, S_T2};
  assign ord_sel = in_cycle && !card_r;
  assign sd_ph = state_r == S_ACT || state_r == S_CMD;
  assign io_range = req_r.addr[CARD_IO_BIT];

  // Area 1 and code 111 never leave idle, so no select fires for them
  for (genvar i = 0; i < NUM_AREAS; i++) begin : g_sel
    assign sel_hit[i] = area_r == 3'(i) && (ord_sel || sd_ph);
  end
  assign area0_select_n = !sel_hit[0];
  assign area2_select_n = !sel_hit[2];
  assign area3_select_n = !sel_hit[3];
  assign area4_select_n = !sel_hit[4];
  assign area5_select_n = !sel_hit[5];
  assign area6_select_n = !sel_hit[6];

  assign read_strobe_n = !(strobe_ph && !req_r.write);
  // A card write uses lane 1 only; ordinary writes follow the byte enables
  for (genvar i = 0; i < 4; i++) begin : g_we
    assign we_hit[i] = strobe_ph && req_r.write &&
                       (card_r ? (i == 1) : req_r.byte_en[i]);
  end
  assign byte_write_strobe0_n = !we_hit[0];
  assign byte_write_strobe1_n = !we_hit[1];
  assign byte_write_strobe2_n = !we_hit[2];
  assign byte_write_strobe3_n = !we_hit[3];

  assign row_strobe_upper_n = state_r != S_ACT;
  assign row_strobe_lower_n = state_r != S_ACT;
  assign column_strobe_upper_n = state_r != S_CMD;
  assign column_strobe_lower_n = state_r != S_CMD;
  assign sdram_write_n = !(state_r == S_CMD && req_r.write);
  assign byte_mask_0 = !(state_r == S_CMD && req_r.byte_en[0]);
  assign byte_mask_1 = !(state_r == S_CMD && req_r.byte_en[1]);
  assign byte_mask_2 = !(state_r == S_CMD && req_r.byte_en[2]);
  assign byte_mask_3 = !(state_r == S_CMD && req_r.byte_en[3]);
  assign row_addr = req_r.addr >> (ROW_SHIFT_BASE + int'(cfg.mux_shift));
  assign mem_addr = (state_r == S_ACT) ? row_addr[MUX_ADDR_W-1:0] :
                    req_r.addr[MUX_ADDR_W-1:0];

  assign card_a_enable1_n = !(in_cycle && card_r && area_r == AREA5);
  assign card_a_enable2_n = !(in_cycle && card_r && area_r == AREA5);
  assign card_b_enable1_n = !(in_cycle && card_r && area_r == AREA6);
  assign card_b_enable2_n = !(in_cycle && card_r && area_r == AREA6);
  assign card_io_read_n = !(strobe_ph && card_r && area_r == AREA6 && io_range && !req_r.write);
  assign card_io_write_n = !(strobe_ph && card_r && area_r == AREA6 && io_range && req_r.write);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_area_decode: assert property (
    accept |=> area_r == $past(req_area))
    else $error("area code not taken from address bits 28..26");

  a_quiet_areas: assert property (
    (area_r == AREA1 || area_r == AREA_NONE) |->
      (area0_select_n && area2_select_n && area3_select_n && area4_select_n &&
       area5_select_n && area6_select_n))
    else $error("external select asserted for area 1 or code 111");

  sequence s_t1_nowait;
    state_r == S_T1 && waits_r == 6'h00;
  endsequence
  sequence s_t2_once;
    state_r == S_T2 ##1 state_r != S_T2;
  endsequence
  a_two_clock: assert property (
    s_t1_nowait |=> s_t2_once)
    else $error("no-wait access did not finish in two clocks");

  a_wait_length: assert property (
    (state_r == S_TW && tw_len_r < waits_r) |-> 6'(tw_len_r + cnt_r) == waits_r)
    else $error("wait phase length differs from programmed count");

  a_ext_stretch: assert property (
    (state_r == S_TW && cnt_r == 6'h01 && wait_en_r && !wait_n) |=> state_r == S_TW)
    else $error("external wait did not stretch the cycle");

  a_wait_gate: assert property (
    state_r != S_IDLE && wait_en_r |-> waits_r != 6'h00 && !sdram_r)
    else $error("external wait enabled without programmed waits");

  sequence s_row;
    !row_strobe_upper_n && !row_strobe_lower_n && column_strobe_upper_n;
  endsequence
  sequence s_col;
    !column_strobe_upper_n && !column_strobe_lower_n && row_strobe_lower_n;
  endsequence
  a_sdram_order: assert property (
    (accept && req_sdram) |=> s_row ##1 s_col ##1 req_ready)
    else $error("sdram row then column order broken");

  a_card_width: assert property (
    (state_r != S_IDLE && card_r) |-> bus_width_r != W_LONG)
    else $error("card access used long width");

  a_burst_pitch: assert property (
    (state_r != S_IDLE && req_r.burst) |-> waits_r <= BURST_MAX_CARD)
    else $error("burst pitch beyond its limit");

  a_setup_load: assert property (
    (accept && ext_area && !req_sdram && req_setup != 3'h0) |=>
      state_r == S_SETUP && cnt_r == {3'h0, $past(req_setup)})
    else $error("strobe setup not applied");

endmodule
`default_nettype wire

/* ead_mem_model.sv */
// Far-side memory and card model that stretches selected cycles through the wait line
`timescale 1ns/1ps
`default_nettype none
module ead_mem_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] sel_n,
  input wire logic [5:0] stretch,
  output logic wait_n
);
  import ead_pkg::*;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic busy;
  assign busy = ~&sel_n;
  assign cnt_nxt = busy ? cnt_r + 8'h01 : 8'h00;
  // Pull-up on the wait line: it reads high whenever no device is selected
  assign wait_n = ~(busy && (cnt_r < {2'h0, stretch}));
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

/* tb.sv */
// Self-checking bench for the external area decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ead_pkg::*;
  localparam int WT [16] = '{0, 1, 2, 3, 4, 6, 8, 10, 12, 14, 18, 22, 26, 30, 34, 38};
  logic clk, sys_rst, req_valid, wait_n, pin_a, pin_b, req_ready, req_done, req_internal;
  logic rd_n, sdw_n;
  logic [1:0] bus_width, io_n, pins;
  logic [3:0] wr_n, ce_n, rc_n, bm;
  logic [5:0] sel_n, stretch, st;
  logic [25:0] mem_addr, row;
  ead_cfg_t cfg, k;
  ead_req_t req;
  logic [5:0] s_sel;
  logic [3:0] s_wr, s_card, s_rc, s_bm;
  logic [1:0] s_io;
  logic s_rd, s_sdw, s_int;
  int dur, num_errors, n_checks, cyc;

  ead_area_decoder dut (
    .clk(clk), .sys_rst(sys_rst), .cfg(cfg), .area0_width_pin_a(pin_a),
    .area0_width_pin_b(pin_b), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .req_done(req_done), .req_internal(req_internal), .wait_n(wait_n),
    .bus_width(bus_width), .mem_addr(mem_addr), .area0_select_n(sel_n[0]),
    .area2_select_n(sel_n[1]), .area3_select_n(sel_n[2]), .area4_select_n(sel_n[3]),
    .area5_select_n(sel_n[4]), .area6_select_n(sel_n[5]), .read_strobe_n(rd_n),
    .byte_write_strobe0_n(wr_n[0]), .byte_write_strobe1_n(wr_n[1]),
    .byte_write_strobe2_n(wr_n[2]), .byte_write_strobe3_n(wr_n[3]),
    .row_strobe_upper_n(rc_n[0]), .row_strobe_lower_n(rc_n[1]),
    .column_strobe_upper_n(rc_n[2]), .column_strobe_lower_n(rc_n[3]),
    .sdram_write_n(sdw_n), .byte_mask_0(bm[0]), .byte_mask_1(bm[1]), .byte_mask_2(bm[2]),
    .byte_mask_3(bm[3]), .card_a_enable1_n(ce_n[0]), .card_a_enable2_n(ce_n[1]),
    .card_b_enable1_n(ce_n[2]), .card_b_enable2_n(ce_n[3]), .card_io_read_n(io_n[0]),
    .card_io_write_n(io_n[1])
  );

  ead_mem_model mem (
    .clk(clk), .sys_rst(sys_rst), .sel_n({ce_n[2], ce_n[0], sel_n}), .stretch(stretch),
    .wait_n(wait_n)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic close_out();
    $display("Checks made %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // A hang ends the run as a mismatch rather than stalling forever
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] mk(input logic [2:0] hi, input logic [2:0] ar,
                                     input logic [25:0] off);
    return {hi, ar, off};
  endfunction

  function automatic logic [5:0] exp_sel(input int c);
    return (c == 0) ? 6'h01 : ((c > 1 && c < 7) ? 6'h01 << (c - 1) : 6'h00);
  endfunction

  // One access; configuration, pins and stretch are applied while the block is idle
  task automatic tx(input logic [31:0] a, input logic w, input logic [3:0] be,
                    input logic b, input int exp);
    @(posedge clk);
    cfg <= k;
    {pin_b, pin_a} <= pins;
    stretch <= st;
    req <= '{addr: a, write: w, byte_en: be, burst: b};
    req_valid <= 1'b1;
    do @(negedge clk); while (req_ready !== 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
    dur = 0;
    {s_sel, s_wr, s_card, s_rc, s_bm, s_io, s_rd, s_sdw, s_int} = '0;
    do begin
      @(negedge clk);
      dur++;
      if (dur == 1) row = mem_addr;
      s_sel |= ~sel_n;
      s_wr |= ~wr_n;
      s_card |= ~ce_n;
      s_rc |= ~rc_n;
      s_bm |= ~bm;
      s_io |= ~io_n;
      s_rd |= ~rd_n;
      s_sdw |= ~sdw_n;
      s_int |= req_internal;
    end while (req_done !== 1'b1 && dur < 400);
    chk(dur, exp);
  endtask

  initial begin
    {sys_rst, req_valid, pin_a, pin_b} = 4'hB;
    req = '0;
    cfg = '0;
    k = '0;
    pins = 2'h3;
    st = 6'h00;
    stretch = 6'h00;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      tx(mk(c[2:0] ^ 3'h5, c[2:0], 26'h0), 1'b0, 4'hF, 1'b0, (c % 6 == 1) ? 1 : 3);
      chk(s_sel, exp_sel(c));
      chk({s_int, s_rd}, (c % 6 == 1) ? 2'h2 : 2'h1);
    end
    tx(mk(3'h0, 3'h2, 26'h4), 1'b1, 4'h5, 1'b0, 3);
    chk({s_rd, s_wr}, 5'h05);
    for (int c = 0; c < 8; c++) begin
      k.area0_wait_field = c[2:0];
      k.area4_wait_field = c[2:0];
      k.area6_wait_field = c[2:0];
      tx(mk(3'h1, 3'h0, 26'h0), 1'b0, 4'hF, 1'b0, 3 + WT[c]);
      tx(mk(3'h2, 3'h4, 26'h8), 1'b1, 4'hF, 1'b0, 3 + WT[c]);
      tx(mk(3'h0, 3'h6, 26'h0), 1'b0, 4'hF, 1'b0, 3 + WT[c]);
    end
    for (int c = 0; c < 4; c++) begin
      k.area2_wait_field = c[1:0];
      k.area3_wait_field = c[1:0];
      tx(mk(3'h0, 3'h2, 26'h0), 1'b0, 4'hF, 1'b0, 3 + c);
      tx(mk(3'h3, 3'h3, 26'h0), 1'b1, 4'hF, 1'b0, 3 + c);
    end
    k = '0;
    k.area5_card = 1'b1;
    for (int c = 0; c < 16; c++) begin
      {k.area5_wait_extra_bit, k.area5_wait_field} = c[3:0];
      tx(mk(3'h0, 3'h5, 26'h0), 1'b0, 4'hF, 1'b0, 3 + WT[c]);
    end
    k = '0;
    k.area6_card = 1'b1;
    for (int c = 1; c < 4; c++) begin
      pins = c[1:0];
      {k.area2_size_field, k.area3_size_field, k.area4_size_field} = {3{c[1:0]}};
      {k.area5_size_field, k.area6_size_field} = {2{c[1:0]}};
      tx(mk(3'h0, 3'h0, 26'h0), 1'b0, 4'hF, 1'b0, 3);
      chk(bus_width, c);
      for (int ar = 2; ar < 5; ar++) begin
        tx(mk(3'h0, ar[2:0], 26'h0), 1'b0, 4'hF, 1'b0, 3);
        chk(bus_width, c);
      end
      tx(mk(3'h0, 3'h5, 26'h0), 1'b0, 4'hF, 1'b0, 3);
      chk(bus_width, c);
      tx(mk(3'h0, 3'h6, 26'h0), 1'b0, 4'hF, 1'b0, 3);
      chk(bus_width, (c == 3) ? 2 : c);
    end
    k.area5_card = 1'b1;
    tx(mk(3'h0, 3'h5, 26'h0), 1'b1, 4'hF, 1'b0, 3);
    chk({s_card, s_wr, s_io}, 10'h0C8);
    tx(mk(3'h2, 3'h5, 26'h2000000), 1'b1, 4'hF, 1'b0, 3);
    chk({s_card, s_io}, 6'h0C);
    tx(mk(3'h0, 3'h6, 26'h2000000), 1'b0, 4'hF, 1'b0, 3);
    chk({s_card, s_rd, s_io}, 7'h65);
    tx(mk(3'h0, 3'h6, 26'h2000010), 1'b1, 4'hF, 1'b0, 3);
    chk({s_card, s_wr, s_io}, 10'h30A);
    tx(mk(3'h0, 3'h6, 26'h1000000), 1'b0, 4'hF, 1'b0, 3);
    chk({s_card, s_io}, 6'h30);
    // Far side holds wait low for three cycles from the start of each selection
    k = '0;
    st = 6'h03;
    k.area2_sdram = 1'b1;
    k.area3_sdram = 1'b1;
    k.area2_wait_field = 2'h1;
    k.mux_shift = 2'h2;
    tx(mk(3'h0, 3'h2, 26'h12345), 1'b1, 4'h3, 1'b0, 3);
    chk({s_rc, s_bm, s_rd, s_wr, s_sdw}, 14'h3CC1);
    chk(row, 26'(mk(3'h0, 3'h2, 26'h12345) >> 10));
    chk(mem_addr, 26'h0012345);
    tx(mk(3'h0, 3'h3, 26'h40), 1'b0, 4'hC, 1'b0, 3);
    chk({s_rc, s_bm, s_sdw, s_sel}, 15'h7E04);
    k.area2_sdram = 1'b0;
    tx(mk(3'h0, 3'h2, 26'h0), 1'b0, 4'hF, 1'b0, 6);
    tx(mk(3'h0, 3'h4, 26'h0), 1'b0, 4'hF, 1'b0, 3);
    k.area4_wait_field = 3'h1;
    k.area5_wait_field = 3'h2;
    k.area6_wait_field = 3'h1;
    k.area6_card = 1'b1;
    tx(mk(3'h0, 3'h4, 26'h0), 1'b1, 4'hF, 1'b0, 6);
    tx(mk(3'h0, 3'h5, 26'h0), 1'b0, 4'hF, 1'b0, 6);
    tx(mk(3'h0, 3'h6, 26'h0), 1'b0, 4'hF, 1'b0, 6);
    k = '0;
    st = 6'h00;
    k.area0_wait_field = 3'h7;
    tx(mk(3'h0, 3'h0, 26'h0), 1'b0, 4'hF, 1'b1, 41);
    k.area0_wait_field = 3'h3;
    tx(mk(3'h0, 3'h0, 26'h0), 1'b0, 4'hF, 1'b1, 21);
    k.area5_wait_field = 3'h7;
    tx(mk(3'h0, 3'h5, 26'h0), 1'b0, 4'hF, 1'b1, 45);
    k.area5_card = 1'b1;
    k.area5_wait_extra_bit = 1'b1;
    tx(mk(3'h0, 3'h5, 26'h0), 1'b0, 4'hF, 1'b1, 157);
    k = '0;
    k.area6_strobe_setup_field = 3'h3;
    k.area6_strobe_hold_field = 3'h2;
    tx(mk(3'h0, 3'h6, 26'h0), 1'b1, 4'hF, 1'b0, 8);
    k.area5_card = 1'b1;
    k.area5_wait_field = 3'h1;
    k.area5_strobe_setup_field = 3'h7;
    k.area5_strobe_hold_field = 3'h1;
    tx(mk(3'h0, 3'h5, 26'h0), 1'b0, 4'hF, 1'b0, 12);
    close_out();
  end
endmodule
`default_nettype wire
